// ---- core/taol_pkg.sv ----
package taol_pkg;
    // fault queue length
    localparam int QUEUE_DEPTH = 3;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int MEAS_TIME_MS = 38;
    localparam int MEAS_CYC = MEAS_TIME_MS * CLK_MHZ * 1000;
    localparam int PERIOD_BASE_MS = 1000;
    localparam int PERIOD_BASE_CYC = PERIOD_BASE_MS * CLK_MHZ * 1000;
    // remote diode fault loads
    localparam logic [7:0] FAULT_OPEN_HIGH = 8'h7F;
    localparam logic [7:0] FAULT_OPEN_LOW = 8'h00;
    localparam logic [7:0] FAULT_SHORT_HIGH = 8'h80;
    localparam logic [7:0] FAULT_SHORT_LOW = 8'h00;
    // status layout
    localparam int ST_BUSY = 7;
    localparam int ST_LHI = 6;
    localparam int ST_LLO = 5;
    localparam int ST_RHI = 4;
    localparam int ST_RLO = 3;
    localparam int ST_OPEN = 2;
    localparam int ST_REMOTE_OVERHEAT_FLAG = 1;
    localparam int ST_LOCAL_OVERHEAT_FLAG = 0;
    localparam logic [7:0] ST_ALARM = 8'h7B;
    localparam logic [7:0] ST_CLEAR = 8'h7F;
    // channels
    localparam int NUM_CH = 2;
    localparam int CH_LOCAL = 0;
    localparam int CH_REMOTE = 1;
    // alert response byte
    localparam int ARA_BITS = 8;
    localparam logic ARA_TAIL = 1'b1;

    typedef enum logic [1:0] {
        TAOL_WAIT,
        TAOL_MEAS_L,
        TAOL_MEAS_R
    } taol_seq_e;
endpackage : taol_pkg

// ---- core/taol_chan_if.sv ----
interface taol_chan_if;
    logic evt;
    logic fq;
    logic signed [7:0] temp;
    logic signed [7:0] hi;
    logic signed [7:0] lo;
    logic signed [7:0] crit;
    logic [4:0] hyst;
    logic hi_act;
    logic lo_act;
    logic crit_act;
    modport ctrl (output evt, fq, temp, hi, lo, crit, hyst,
                  input hi_act, lo_act, crit_act);
    modport chan (input evt, fq, temp, hi, lo, crit, hyst,
                  output hi_act, lo_act, crit_act);
endinterface : taol_chan_if

// ---- core/taol_chan.sv ----
module taol_chan
    import taol_pkg::*;
(
    // clock and reset
    input logic clock_i,
    input logic resetn_i,
    // evaluation
    taol_chan_if.chan b
);
    typedef struct packed {
        logic [1:0] hi_cnt;
        logic [1:0] lo_cnt;
        logic [1:0] up_cnt;
        logic [1:0] dn_cnt;
        logic hi_act;
        logic lo_act;
        logic crit_act;
    } taol_chan_s;

    taol_chan_s st_ff;
    taol_chan_s nxt;
    logic [1:0] need;
    logic signed [8:0] rel_lvl;

    function automatic logic [1:0] bump(input logic [1:0] c,
                                        input logic [1:0] n);
        bump = (c >= n) ? n : c + 2'd1;
    endfunction : bump

    always_comb
    begin
        nxt = st_ff;
        need = b.fq ? 2'(QUEUE_DEPTH) : 2'd1;
        rel_lvl = 9'(b.crit) - $signed({4'h0, b.hyst});
        if (b.evt)
        begin
            if (b.temp > b.hi)
            begin
                nxt.hi_cnt = bump(st_ff.hi_cnt, need);
                nxt.hi_act = (nxt.hi_cnt == need);
            end
            else
            begin
                nxt.hi_cnt = 2'd0;
                nxt.hi_act = 1'b0;
            end
            if (b.temp < b.lo)
            begin
                nxt.lo_cnt = bump(st_ff.lo_cnt, need);
                nxt.lo_act = (nxt.lo_cnt == need);
            end
            else
            begin
                nxt.lo_cnt = 2'd0;
                nxt.lo_act = 1'b0;
            end
            if (b.temp > b.crit)
            begin
                nxt.up_cnt = bump(st_ff.up_cnt, need);
                nxt.dn_cnt = 2'd0;
                if (nxt.up_cnt == need)
                    nxt.crit_act = 1'b1;
            end
            else
            begin
                nxt.up_cnt = 2'd0;
                if (9'(b.temp) < rel_lvl)
                begin
                    nxt.dn_cnt = bump(st_ff.dn_cnt, need);
                    if (nxt.dn_cnt == need)
                        nxt.crit_act = 1'b0;
                end
                else
                    nxt.dn_cnt = 2'd0;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
            st_ff <= '0;
        else
            st_ff <= nxt;
    end

    assign b.hi_act = st_ff.hi_act;
    assign b.lo_act = st_ff.lo_act;
    assign b.crit_act = st_ff.crit_act;

    a_queue_holds_off: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        b.evt && b.fq && st_ff.hi_cnt == 2'd0 |=> !b.hi_act)
        else $error("high alarm raised before third reading");
    a_single_release: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        b.evt && b.temp <= b.hi |=> !b.hi_act)
        else $error("high alarm kept after in-limit reading");
    a_low_queue: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        b.evt && b.fq && st_ff.lo_cnt == 2'd0 |=> !b.lo_act)
        else $error("low alarm raised before third reading");
    a_crit_hold: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        b.evt && b.fq && st_ff.crit_act && st_ff.dn_cnt == 2'd0
        |=> b.crit_act)
        else $error("overheat released after one cool reading");
endmodule : taol_chan

// ---- core/taol_ara.sv ----
module taol_ara
    import taol_pkg::*;
(
    // link clock and reset
    input logic smb_clk_i,
    input logic resetn_i,
    // request from system domain
    input logic req_i,
    input logic [6:0] slave_addr_i,
    // link
    input logic ara_hit_i,
    input logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // completion toggle
    output logic done_tgl_o
);
    typedef struct packed {
        logic rst1;
        logic rst2;
        logic req1;
        logic req2;
        logic active;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic oe;
        logic done;
    } taol_ara_s;

    taol_ara_s st_ff;
    taol_ara_s nxt;

    always_comb
    begin
        nxt = st_ff;
        nxt.rst1 = resetn_i;
        nxt.rst2 = st_ff.rst1;
        nxt.req1 = req_i;
        nxt.req2 = st_ff.req1;
        if (!st_ff.rst2)
        begin
            nxt.active = 1'b0;
            nxt.oe = 1'b0;
            nxt.done = 1'b0;
            nxt.cnt = 3'd0;
            nxt.shift = '0;
        end
        else if (!st_ff.active)
        begin
            if (ara_hit_i && st_ff.req2)
            begin
                nxt.active = 1'b1;
                nxt.shift = {slave_addr_i, ARA_TAIL};
                nxt.cnt = 3'd0;
                nxt.oe = ~slave_addr_i[6];
            end
        end
        // released one but line low: lost
        else if (!st_ff.oe && !sda_i && st_ff.cnt != 3'(ARA_BITS - 1))
        begin
            nxt.active = 1'b0;
            nxt.oe = 1'b0;
        end
        else if (st_ff.cnt == 3'(ARA_BITS - 1))
        begin
            // address sent, report to system side
            nxt.active = 1'b0;
            nxt.oe = 1'b0;
            nxt.done = ~st_ff.done;
        end
        else
        begin
            nxt.shift = {st_ff.shift[6:0], 1'b0};
            nxt.cnt = st_ff.cnt + 3'd1;
            nxt.oe = ~st_ff.shift[6];
        end
    end

    always_ff @(posedge smb_clk_i)
    begin
        st_ff <= nxt;
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = st_ff.oe;
    assign done_tgl_o = st_ff.done;

    a_ara_needs_req: assert property (
        @(posedge smb_clk_i) disable iff (!st_ff.rst2)
        ara_hit_i && !st_ff.active && !st_ff.req2 |=> !sda_oe_o)
        else $error("answered alert read while not asserting");
    a_ara_tail_one: assert property (
        @(posedge smb_clk_i) disable iff (!st_ff.rst2)
        st_ff.active && st_ff.cnt == 3'd7 |-> !sda_oe_o)
        else $error("response bit 0 not one");
    a_ara_loser_stops: assert property (
        @(posedge smb_clk_i) disable iff (!st_ff.rst2)
        st_ff.active && !sda_oe_o && !sda_i && st_ff.cnt != 3'd7
        |=> !st_ff.active && !sda_oe_o)
        else $error("kept driving after losing arbitration");
endmodule : taol_ara

// ---- core/taol_top.sv ----
// Function
// - after sending its alert address, release attention and set the mask
// - mask set keeps attention inactive until software clears it
// - alert response only in interrupt style, never in comparator style
// - reset clears attention mask and attention style
// - host reads alert address 0001100; asserting devices acknowledge
// - lowest address wins arbitration; losers keep asserting
// - response byte is address in bits 7..1, bit 0 one
// - overheat output low when a reading exceeds its critical setpoint
// - crossing critical setpoint sets status bit 1 remote, 0 local
// - flags and overheat output update after every conversion
// - overheat releases below setpoint minus hysteresis; flag unchanged
// - interrupt style: status read clears the flags
// - fault queue: three bad readings before attention or overheat
// - queue off at reset; enabled by configuration bit 0
// - fault queue: three cool readings before overheat releases
// - one in-limit reading releases the high or low alarm
// - fault queue: three low readings before low alarm
// - each measurement lasts 38 ms inside a programmable period
// - open diode loads 127 and 0, sets bit 2, no attention
// - shorted diode loads -128, bit 2 stays clear
// - fault values pass through normal limit checks
// - mask clear, style 0: any alarm status bit drives attention low
// - style 0 latches, style 1 follows the condition
module taol_top
    import taol_pkg::*;
#(
    parameter int unsigned MEAS_CYCLES = MEAS_CYC,
    parameter int unsigned PERIOD_CYCLES = PERIOD_BASE_CYC
)
(
    // clocks and reset
    input logic clock_i,
    input logic resetn_i,
    input logic smb_clk_i,
    // configuration
    input logic cfg_wr_i,
    input logic cfg_mask_i,
    input logic cfg_queue_i,
    input logic style_wr_i,
    input logic style_i,
    input logic [3:0] conv_rate_i,
    input logic [6:0] slave_addr_i,
    input logic status_rd_i,
    // setpoints
    input logic [7:0] local_upper_limit_i,
    input logic [7:0] local_lower_limit_i,
    input logic [7:0] local_overheat_setpoint_i,
    input logic [7:0] remote_upper_limit_high_byte_i,
    input logic [7:0] remote_lower_limit_high_byte_i,
    input logic [7:0] remote_overheat_setpoint_i,
    input logic [4:0] overheat_hysteresis_i,
    // measurement front end
    input logic [7:0] meas_high_i,
    input logic [2:0] meas_low_i,
    input logic diode_open_i,
    input logic diode_short_i,
    output logic meas_start_o,
    output logic meas_remote_o,
    // serial link
    input logic ara_hit_i,
    input logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // alarm pins
    output logic attn_o,
    output logic attn_oe_o,
    output logic overheat_out_n_o,
    // visible state
    output logic [7:0] status_o,
    output logic cfg_mask_o,
    output logic cfg_queue_o,
    output logic attn_style_o,
    output logic [7:0] local_result_o,
    output logic [7:0] remote_result_high_byte_o,
    output logic [7:0] remote_result_low_byte_o
);
    typedef struct packed {
        taol_seq_e seq;
        logic [31:0] pcnt;
        logic [31:0] mcnt;
        logic [1:0] evt;
        logic [1:0] evt_d;
        logic mask;
        logic queue;
        logic style;
        logic [7:0] status;
        logic [7:0] local_res;
        logic [7:0] rem_hi;
        logic [7:0] rem_lo;
        logic done1;
        logic done2;
        logic done3;
        logic ara_req;
        logic attn_oe;
        logic ovh_n;
        logic meas_start;
        logic meas_rem;
    } taol_top_s;

    taol_top_s st_ff;
    taol_top_s nxt;
    logic [31:0] period;
    logic [7:0] set_v;
    logic ara_done;
    logic rem_done;
    logic attn_src;
    logic done_tgl;
    logic [NUM_CH-1:0] hi_act;
    logic [NUM_CH-1:0] lo_act;
    logic [NUM_CH-1:0] crit_act;

    taol_chan_if ch[NUM_CH]();

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        taol_chan u_chan (
            .clock_i(clock_i),
            .resetn_i(resetn_i),
            .b(ch[g])
        );
        // fault-loaded values checked like any reading
        assign ch[g].temp = (g == CH_LOCAL) ? st_ff.local_res : st_ff.rem_hi;
        assign ch[g].hi = (g == CH_LOCAL) ? local_upper_limit_i
                                          : remote_upper_limit_high_byte_i;
        assign ch[g].lo = (g == CH_LOCAL) ? local_lower_limit_i
                                          : remote_lower_limit_high_byte_i;
        assign ch[g].crit = (g == CH_LOCAL) ? local_overheat_setpoint_i
                                            : remote_overheat_setpoint_i;
        assign ch[g].hyst = overheat_hysteresis_i;
        assign ch[g].evt = st_ff.evt[g];
        assign ch[g].fq = st_ff.queue;
        assign hi_act[g] = ch[g].hi_act;
        assign lo_act[g] = ch[g].lo_act;
        assign crit_act[g] = ch[g].crit_act;
    end

    taol_ara u_ara (
        .smb_clk_i(smb_clk_i),
        .resetn_i(resetn_i),
        .req_i(st_ff.ara_req),
        .slave_addr_i(slave_addr_i),
        .ara_hit_i(ara_hit_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .done_tgl_o(done_tgl)
    );

    always_comb
    begin
        nxt = st_ff;
        // period set by rate, measurement fixed length
        period = PERIOD_CYCLES >> conv_rate_i;
        rem_done = (st_ff.seq == TAOL_MEAS_R)
                   && (st_ff.mcnt == MEAS_CYCLES - 32'd1);
        nxt.pcnt = st_ff.pcnt + 32'd1;
        nxt.mcnt = st_ff.mcnt + 32'd1;
        nxt.evt = '0;
        nxt.evt_d = st_ff.evt;
        nxt.meas_start = 1'b0;
        unique case (st_ff.seq)
            TAOL_WAIT:
            begin
                nxt.mcnt = 32'd0;
                if (st_ff.pcnt >= period)
                begin
                    nxt.seq = TAOL_MEAS_L;
                    nxt.pcnt = 32'd0;
                    nxt.meas_start = 1'b1;
                    nxt.meas_rem = 1'b0;
                end
            end
            TAOL_MEAS_L:
            begin
                if (st_ff.mcnt == MEAS_CYCLES - 32'd1)
                begin
                    nxt.local_res = meas_high_i;
                    nxt.evt[CH_LOCAL] = 1'b1;
                    nxt.seq = TAOL_MEAS_R;
                    nxt.mcnt = 32'd0;
                    nxt.meas_start = 1'b1;
                    nxt.meas_rem = 1'b1;
                end
            end
            TAOL_MEAS_R:
            begin
                if (rem_done)
                begin
                    nxt.evt[CH_REMOTE] = 1'b1;
                    nxt.seq = TAOL_WAIT;
                    nxt.mcnt = 32'd0;
                    if (diode_open_i)
                    begin
                        nxt.rem_hi = FAULT_OPEN_HIGH;
                        nxt.rem_lo = FAULT_OPEN_LOW;
                    end
                    else if (diode_short_i)
                    begin
                        nxt.rem_hi = FAULT_SHORT_HIGH;
                        nxt.rem_lo = FAULT_SHORT_LOW;
                    end
                    else
                    begin
                        nxt.rem_hi = meas_high_i;
                        nxt.rem_lo = {meas_low_i, 5'h00};
                    end
                end
            end
        endcase

        set_v = '0;
        set_v[ST_LHI] = st_ff.evt_d[CH_LOCAL] && hi_act[CH_LOCAL];
        set_v[ST_LLO] = st_ff.evt_d[CH_LOCAL] && lo_act[CH_LOCAL];
        set_v[ST_LOCAL_OVERHEAT_FLAG] = st_ff.evt_d[CH_LOCAL] && crit_act[CH_LOCAL];
        set_v[ST_RHI] = st_ff.evt_d[CH_REMOTE] && hi_act[CH_REMOTE];
        set_v[ST_RLO] = st_ff.evt_d[CH_REMOTE] && lo_act[CH_REMOTE];
        set_v[ST_REMOTE_OVERHEAT_FLAG] = st_ff.evt_d[CH_REMOTE] && crit_act[CH_REMOTE];
        set_v[ST_OPEN] = rem_done && diode_open_i;
        // clear on read in interrupt style only; set wins
        if (status_rd_i && !st_ff.style)
            nxt.status = (st_ff.status & ~ST_CLEAR) | set_v;
        else
            nxt.status = st_ff.status | set_v;
        nxt.status[ST_BUSY] = (nxt.seq != TAOL_WAIT);

        // completion toggle from the link side
        nxt.done1 = done_tgl;
        nxt.done2 = st_ff.done1;
        nxt.done3 = st_ff.done2;
        ara_done = st_ff.done2 ^ st_ff.done3;

        if (cfg_wr_i)
        begin
            nxt.mask = cfg_mask_i;
            nxt.queue = cfg_queue_i;
        end
        if (style_wr_i)
            nxt.style = style_i;
        // hardware set of the mask wins over a write
        if (ara_done)
            nxt.mask = 1'b1;
        if (status_rd_i && !st_ff.style && |(st_ff.status & ST_ALARM))
            nxt.mask = 1'b1;

        if (nxt.style)
            attn_src = |{hi_act, lo_act, crit_act};
        else
            attn_src = |(nxt.status & ST_ALARM);
        nxt.attn_oe = !nxt.mask && attn_src;
        // only interrupt style answers the alert read
        nxt.ara_req = nxt.attn_oe && !nxt.style;
        nxt.ovh_n = !(|crit_act);
    end

    always_ff @(posedge clock_i)
    begin
        // mask, style and queue all cleared
        if (!resetn_i)
        begin
            st_ff <= '0;
            st_ff.ovh_n <= 1'b1;
        end
        else
            st_ff <= nxt;
    end

    assign meas_start_o = st_ff.meas_start;
    assign meas_remote_o = st_ff.meas_rem;
    assign attn_o = 1'b0;
    assign attn_oe_o = st_ff.attn_oe;
    assign overheat_out_n_o = st_ff.ovh_n;
    assign status_o = st_ff.status;
    assign cfg_mask_o = st_ff.mask;
    assign cfg_queue_o = st_ff.queue;
    assign attn_style_o = st_ff.style;
    assign local_result_o = st_ff.local_res;
    assign remote_result_high_byte_o = st_ff.rem_hi;
    assign remote_result_low_byte_o = st_ff.rem_lo;

    a_ara_sets_mask: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        st_ff.done2 != st_ff.done3 |=> cfg_mask_o && !attn_oe_o)
        else $error("alert answer did not set mask");
    a_mask_keeps_off: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        cfg_mask_o && !cfg_wr_i |=> !attn_oe_o)
        else $error("attention driven while masked");
    a_por_defaults: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> !cfg_mask_o && !attn_style_o && !cfg_queue_o)
        else $error("configuration not cleared by reset");
    a_ovh_on_conv: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        $fell(overheat_out_n_o) |-> $past(st_ff.evt, 2) != 2'b00)
        else $error("overheat changed outside a conversion end");
    a_crit_flag_set: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        st_ff.evt_d[CH_REMOTE] && crit_act[CH_REMOTE] |=> status_o[ST_REMOTE_OVERHEAT_FLAG])
        else $error("remote overheat flag not set");
    a_flag_on_release: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        $rose(overheat_out_n_o) && $past(status_o[ST_REMOTE_OVERHEAT_FLAG])
        && !$past(status_rd_i) |-> status_o[ST_REMOTE_OVERHEAT_FLAG])
        else $error("flag changed when overheat released");
    a_status_clears: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        status_rd_i && !attn_style_o && set_v == 8'h00
        |=> (status_o & ST_ALARM) == 8'h00)
        else $error("status not cleared by read");
    a_open_loads: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        rem_done && diode_open_i |=> remote_result_high_byte_o ==
        FAULT_OPEN_HIGH && remote_result_low_byte_o == FAULT_OPEN_LOW
        && status_o[ST_OPEN])
        else $error("open diode values not loaded");
    a_short_loads: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        rem_done && !diode_open_i && diode_short_i
        |=> remote_result_high_byte_o == FAULT_SHORT_HIGH)
        else $error("shorted diode value not loaded");
endmodule : taol_top

// ---- test/taol_host_model.sv ----
module taol_host_model (
    // link toward the device
    output logic smb_clk_o = 1'b0,
    output logic ara_hit_o = 1'b0,
    output logic sda_o,
    input wire logic sda_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up wins unless the device pulls low
    assign sda_o = ~sda_oe_i;
    // alert read, msb first
    // device puts bit 7 out at the hit edge, one bit per rise after it
    task automatic ara_read(output logic [7:0] b);
        for (int k = -3; k < 10; k++)
        begin
            ara_hit_o = (k == 0);
            #80 smb_clk_o = 1'b1;
            #79 if (k >= 0 && k < 8) b[7 - k] = sda_o;
            #1 smb_clk_o = 1'b0;
        end
    endtask : ara_read
endmodule : taol_host_model

// ---- test/taol_top_tb.sv ----
module taol_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, resetn_i = 1'b0, cfg_wr_i = 1'b0, style_i = 1'b0;
    logic cfg_mask_i = 1'b0, cfg_queue_i = 1'b0, style_wr_i = 1'b0;
    logic status_rd_i = 1'b0, diode_open_i = 1'b0, diode_short_i = 1'b0;
    logic smb_clk_i, ara_hit_i, sda_i, sda_oe_o, meas_start_o, meas_remote_o;
    logic attn_oe_o, overheat_out_n_o, cfg_mask_o, cfg_queue_o, attn_style_o;
    logic [3:0] conv_rate_i = 4'h0;
    logic [6:0] slave_addr_i = 7'h4C;
    logic [7:0] local_upper_limit_i = 8'h7F, local_lower_limit_i = 8'h80;
    logic [7:0] local_overheat_setpoint_i = 8'h7F, meas_high_i = 8'h14;
    logic [7:0] remote_upper_limit_high_byte_i = 8'h37, b;
    logic [7:0] remote_lower_limit_high_byte_i = 8'hD8;
    logic [7:0] remote_overheat_setpoint_i = 8'h32, status_o, local_result_o;
    logic [7:0] remote_result_high_byte_o, remote_result_low_byte_o;
    logic [4:0] overheat_hysteresis_i = 5'h0A;
    logic [2:0] meas_low_i = 3'h5;
    int errors = 0, check_count = 0;
    always #5 clock_i = ~clock_i;
    taol_top #(.MEAS_CYCLES(20), .PERIOD_CYCLES(100)) u_taol_top (
        .sda_o(), .attn_o(), .*);
    taol_host_model u_taol_host_model (.smb_clk_o(smb_clk_i),
        .ara_hit_o(ara_hit_i), .sda_o(sda_i), .sda_oe_i(sda_oe_o));
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : cyc
    task automatic chk(input string s, input logic [7:0] e, g);
        check_count++;
        errors += int'(g !== e);
        if (g !== e) $display("mismatch %s expected %h seen %h", s, e, g);
    endtask : chk
    task automatic pins(input logic [2:0] e);
        chk("attn_ovh_mask", 8'(e),
            8'({attn_oe_o, overheat_out_n_o, cfg_mask_o}));
    endtask : pins
    task automatic cmd(input logic [2:0] p);
        {cfg_wr_i, style_wr_i, status_rd_i} = p;
        cyc(1);
        {cfg_wr_i, style_wr_i, status_rd_i} = 3'h0;
        cyc(4);
    endtask : cmd
    task automatic step(input logic [7:0] m, input int n);
        int k;
        meas_high_i = m;
        repeat (n)
        begin
            for (k = 0; k < 300 && meas_start_o !== 1'b1; k++) cyc(1);
            cyc(1);
            for (k = 1; k < 300 && meas_start_o !== 1'b1; k++) cyc(1);
            chk("meas_cycles", 8'h14, 8'(k));
            chk("meas_remote", 8'h01, 8'(meas_remote_o));
            cyc(28);
        end
    endtask : step
    task automatic clean();
        {style_i, cfg_queue_i} = 2'h0;
        cmd(3'b110);
        step(8'h14, 1);
        cmd(3'b001);
        cmd(3'b100);
    endtask : clean
    task automatic do_reset();
        resetn_i = 1'b0;
        u_taol_host_model.ara_read(b);
        cyc(10);
        resetn_i = 1'b1;
        cyc(2);
        chk("cfg", 8'h00, 8'({cfg_mask_o, attn_style_o, cfg_queue_o}));
        pins(3'b010);
    endtask : do_reset
    task automatic s_crit();
        step(8'h3C, 1);
        pins(3'b100);
        chk("status", 8'h12, status_o & 8'h7F);
        chk("low_byte", 8'hA0, remote_result_low_byte_o);
        chk("local_result", 8'h3C, local_result_o);
        step(8'h2D, 1);
        pins(3'b100);
        step(8'h27, 1);
        pins(3'b110);
        chk("status", 8'h12, status_o & 8'h7F);
        cmd(3'b001);
        pins(3'b011);
        chk("status", 8'h00, status_o & 8'h7F);
        step(8'h3C, 1);
        pins(3'b001);
        cmd(3'b100);
        pins(3'b100);
        clean();
    endtask : s_crit
    task automatic s_ara();
        step(8'h3C, 1);
        u_taol_host_model.ara_read(b);
        cyc(5);
        chk("ara_byte", {slave_addr_i, 1'b1}, b);
        pins(3'b001);
        clean();
    endtask : s_ara
    task automatic s_cmp();
        style_i = 1'b1;
        cmd(3'b010);
        step(8'h3C, 1);
        u_taol_host_model.ara_read(b);
        chk("ara_byte", 8'hFF, b);
        pins(3'b100);
        step(8'h14, 1);
        pins(3'b010);
        clean();
    endtask : s_cmp
    task automatic s_queue();
        {style_i, cfg_queue_i} = 2'h3;
        overheat_hysteresis_i = 5'h14;
        cmd(3'b110);
        step(8'hCE, 2);
        pins(3'b010);
        step(8'hCE, 1);
        pins(3'b110);
        step(8'h14, 1);
        pins(3'b010);
        step(8'h3C, 2);
        pins(3'b010);
        step(8'h3C, 1);
        pins(3'b100);
        step(8'h14, 2);
        chk("overheat", 8'h00, 8'(overheat_out_n_o));
        step(8'h14, 1);
        chk("overheat", 8'h01, 8'(overheat_out_n_o));
        clean();
    endtask : s_queue
    task automatic s_fault();
        diode_short_i = 1'b1;
        step(8'h14, 1);
        chk("result_high", 8'h80, remote_result_high_byte_o);
        chk("status", 8'h08, status_o & 8'h7F);
        pins(3'b110);
        diode_short_i = 1'b0;
        clean();
        remote_upper_limit_high_byte_i = 8'h7F;
        remote_overheat_setpoint_i = 8'h7F;
        diode_open_i = 1'b1;
        step(8'h14, 1);
        chk("result_high", 8'h7F, remote_result_high_byte_o);
        chk("result_low", 8'h00, remote_result_low_byte_o);
        chk("status", 8'h04, status_o & 8'h7F);
        pins(3'b010);
    endtask : s_fault
    task automatic results();
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial
    begin
        do_reset();
        s_crit();
        s_ara();
        s_cmp();
        s_queue();
        s_fault();
        {style_i, cfg_mask_i, cfg_queue_i} = 3'h7;
        cmd(3'b110);
        do_reset();
        results();
    end
    initial
    begin
        #200_000 errors++;
        results();
    end
endmodule : taol_top_tb
